// >>> verilog/frc_pkg.sv
// fault retry controller: shared constants, register map, types
// assumes one 200 MHz clock and an AXI4-Lite master on the same clock
`default_nettype none

package frc_pkg;
    // timing: one wait unit of 0.1 s
    localparam int CLK_HZ        = 200_000_000;
    localparam int WAIT_UNIT_MS  = 100;
    localparam int TICK_CYCLES   = CLK_HZ / 1000 * WAIT_UNIT_MS;
    localparam int WAIT_MAX_S    = 360;
    localparam int WAIT_DEF_S    = 1;
    localparam int WAIT_ZERO_MS  = 100;
    localparam logic [15:0] WAIT_MAX  = 16'(WAIT_MAX_S * 1000 / WAIT_UNIT_MS);
    localparam logic [15:0] WAIT_RST  = 16'(WAIT_DEF_S * 1000 / WAIT_UNIT_MS);
    localparam logic [15:0] WAIT_ZERO = 16'(WAIT_ZERO_MS / WAIT_UNIT_MS);
    localparam int SUCCESS_MULT  = 4;
    // setting encodings
    localparam logic [15:0] SEL_MAX       = 16'h0005;
    localparam logic [15:0] LIM_DIR_MAX   = 16'h000a;
    localparam logic [15:0] LIM_HOLD_BASE = 16'h0064;
    localparam logic [15:0] LIM_HOLD_MAX  = 16'h006e;
    localparam logic [15:0] COAST_OFF     = 16'h270f;
    localparam logic [15:0] TERM_POS      = 16'h0040;
    localparam logic [15:0] TERM_NEG      = 16'h00a4;
    // retry sets, one bit per fault code
    localparam logic [19:0] SET_ALL   = 20'hfffff;
    localparam logic [19:0] SET_OC    = 20'h00007;
    localparam logic [19:0] SET_OV    = 20'h00038;
    localparam logic [19:0] SET_OCOV  = 20'h0003f;
    localparam logic [19:0] SET_NOTH  = 20'hff73f;
    localparam logic [19:0] SET_OC_AC = 20'h00005;
    // register byte offsets
    localparam logic [4:0] REG_SEL   = 5'h00;
    localparam logic [4:0] REG_LIM   = 5'h04;
    localparam logic [4:0] REG_WAIT  = 5'h08;
    localparam logic [4:0] REG_SUCC  = 5'h0c;
    localparam logic [4:0] REG_COAST = 5'h10;
    localparam logic [4:0] REG_TERM  = 5'h14;
    localparam logic [4:0] REG_STAT  = 5'h18;
    // status fields
    localparam int STAT_FAIL_LSB  = 0;
    localparam int STAT_CODE_LSB  = 8;
    localparam int STAT_STATE_LSB = 16;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        OVERCURRENT_TRIP_A, OVERCURRENT_TRIP_B, OVERCURRENT_TRIP_C,
        OVERVOLTAGE_TRIP_A, OVERVOLTAGE_TRIP_B, OVERVOLTAGE_TRIP_C,
        MOTOR_THERMAL_TRIP, DRIVE_THERMAL_TRIP, BRAKE_CIRCUIT_TRIP,
        GROUND_FAULT_TRIP, USB_COMM_TRIP, EXTERNAL_THERMAL_TRIP,
        STALL_OVERLOAD_TRIP, OPTION_CARD_TRIP, PARAM_STORE_FAULT,
        BRAKE_SEQUENCE_TRIP_A, BRAKE_SEQUENCE_TRIP_B,
        BRAKE_SEQUENCE_TRIP_C, BRAKE_SEQUENCE_TRIP_D,
        INPUT_PHASE_LOSS_TRIP
    } frc_code_t;

    typedef enum logic [2:0] {
        ST_RUN, ST_WAIT, ST_WATCH, ST_HOLD, ST_EXCESS
    } frc_state_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } frc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } frc_axi_rsp_t;
endpackage : frc_pkg

`default_nettype wire

// >>> verilog/frc_tick_gen.sv
// fault retry controller: 0.1 s tick generator
// assumes an asynchronous active-low reset already released cleanly
`default_nettype none

module frc_tick_gen #(
    parameter int TICKS = 20_000_000
) (
    input  wire logic ref_clk,
    input  wire logic rstN,
    input  wire logic restart,
    output logic      tick
);
    import frc_pkg::*;

    localparam int CW = $clog2(TICKS);

    generate
        if (TICKS < 2) begin : g_bad
            $error("frc_tick_gen: TICKS below 2");
        end
    endgenerate

    logic [CW-1:0] cnt_r; // cycles within the current tick

    // restart realigns the tick grid to the start of a timed interval
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (restart) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r == CW'(TICKS - 1)) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule : frc_tick_gen

`default_nettype wire

// >>> verilog/frc_axil_slave.sv
// fault retry controller: AXI4-Lite slave front end
// assumes the register file answers reads combinationally
`default_nettype none

module frc_axil_slave (
    input  wire logic                 ref_clk,
    input  wire logic                 rstN,
    input  wire frc_pkg::frc_axi_req_t req,
    output frc_pkg::frc_axi_rsp_t     rsp,
    output logic                      wrEn,
    output logic [31:0]               wrAddr,
    output logic [31:0]               wrData,
    output logic [3:0]                wrStrb,
    input  wire logic                 wrOk,
    output logic [31:0]               rdAddr,
    input  wire logic [31:0]          rdData,
    input  wire logic                 rdOk
);
    import frc_pkg::*;

    logic        bvalid_r; // write answer pending
    logic [1:0]  bresp_r;
    logic        rvalid_r; // read answer pending
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic        wrGo;
    logic        rdGo;

    // address and data taken together, one write at a time
    assign wrGo   = req.awvalid && req.wvalid && !bvalid_r;
    assign rdGo   = req.arvalid && !rvalid_r;
    assign wrEn   = wrGo;
    assign wrAddr = req.awaddr;
    assign wrData = req.wdata;
    assign wrStrb = req.wstrb;
    assign rdAddr = req.araddr;
    assign rsp    = {wrGo, wrGo, bvalid_r, bresp_r, rdGo, rvalid_r, rdata_r, rresp_r};

    // write answer, unmapped gets slverr
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wrGo) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wrOk ? RESP_OKAY : RESP_SLVERR;
        end else if (req.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read answer, data captured at acceptance
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0;
        end else if (rdGo) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rdOk ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= rdData;
        end else if (req.rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : frc_axil_slave

`default_nettype wire

// >>> verilog/frc_fault_retry.sv
// fault retry controller: retry sequencer and register file
// assumes trip reports come from logic on ref_clk; external reset is a pin
`default_nettype none

module frc_fault_retry #(
    parameter int TICK_CYCLES = frc_pkg::TICK_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire frc_pkg::frc_axi_req_t axiReq,
    output frc_pkg::frc_axi_rsp_t     axiRsp,
    input  wire logic                 tripValid,
    input  wire frc_pkg::frc_code_t   tripCode,
    input  wire logic                 storeFaultAtPowerOn,
    input  wire logic                 extResetReq,
    output logic                      faultOut,
    output logic                      retryActiveOut,
    output logic                      terminalOut,
    output logic                      retryExcessFault,
    output logic                      faultClearPulse,
    output logic                      restartPulse,
    output logic                      restartFlying,
    output logic                      thermDataClear,
    output frc_pkg::frc_code_t        firstFaultCode
);
    import frc_pkg::*;

    logic [1:0]  rstSync_r;   // reset release synchroniser
    logic        rstN;
    logic [1:0]  extSync_r;   // external reset pin synchroniser
    logic        wrEn;
    logic [31:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    logic [31:0] rdAddr;
    logic [31:0] rdData;
    logic        tick;
    logic [15:0] sel_r;       // retry_fault_select
    logic [15:0] lim_r;       // retry_count_limit
    logic [15:0] wait_r;      // retry_wait_time, 0.1 s units
    logic [15:0] succ_r;      // retry_success_count
    logic [15:0] coast_r;     // restart_coast_time
    logic [15:0] term_r;      // output_terminal_select
    frc_state_t  state_r;
    frc_code_t   code_r;      // first fault of the episode
    logic [3:0]  failCnt_r;   // consecutive retries attempted
    logic [15:0] waitLat_r;   // wait latched at trip
    logic [15:0] tickCnt_r;   // ticks since interval start
    logic        tickClr_r;
    logic        porDone_r;
    logic        retryOk;
    logic        expire;
    logic        success;
    logic        succClr;
    logic [15:0] wrVal;

    // true when this fault may start a retry
    function automatic logic inSet(input logic [15:0] sel, input frc_code_t c);
        logic [19:0] m;
        m = 20'h0;
        case (sel)
            16'h0000: m = SET_ALL;
            16'h0001: m = SET_OC;
            16'h0002: m = SET_OV;
            16'h0003: m = SET_OCOV;
            16'h0004: m = SET_NOTH;
            16'h0005: m = SET_OC_AC;
            default:  m = 20'h0;
        endcase
        inSet = m[c];
    endfunction : inSet

    // allowed retries for a limit setting, zero when disabled
    function automatic logic [3:0] allowed(input logic [15:0] lim);
        allowed = 4'h0;
        if (lim != 16'h0 && lim <= LIM_DIR_MAX)
            allowed = lim[3:0];
        else if (lim > LIM_HOLD_BASE && lim <= LIM_HOLD_MAX)
            allowed = 4'(lim - LIM_HOLD_BASE);
    endfunction : allowed

    // hold mode keeps the fault output up during retry
    function automatic logic holdMode(input logic [15:0] lim);
        holdMode = lim > LIM_HOLD_BASE && lim <= LIM_HOLD_MAX;
    endfunction : holdMode

    function automatic logic mapped(input logic [31:0] a);
        mapped = a[31:5] == 27'h0 && a[1:0] == 2'b00 && a[4:0] <= REG_STAT;
    endfunction : mapped

    // reset released through two flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            rstSync_r <= 2'b00;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    // external reset pin, two flops before use
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN)
            extSync_r <= 2'b00;
        else
            extSync_r <= {extSync_r[0], extResetReq};
    end

    frc_axil_slave u_bus (
        .ref_clk (ref_clk),
        .rstN    (rstN),
        .req     (axiReq),
        .rsp     (axiRsp),
        .wrEn    (wrEn),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .wrStrb  (wrStrb),
        .wrOk    (mapped(wrAddr)),
        .rdAddr  (rdAddr),
        .rdData  (rdData),
        .rdOk    (mapped(rdAddr))
    );

    frc_tick_gen #(
        .TICKS (TICK_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .rstN    (rstN),
        .restart (tickClr_r),
        .tick    (tick)
    );

    // byte lanes 0 and 1 carry the 16-bit settings
    assign wrVal = {wrStrb[1] ? wrData[15:8] : 8'h0, wrStrb[0] ? wrData[7:0] : 8'h0};

    // decision on a trip: selected, enabled, not power-on store fault
    assign retryOk = inSet(sel_r, tripCode) && allowed(lim_r) != 4'h0
        && !(tripCode == PARAM_STORE_FAULT && storeFaultAtPowerOn);
    assign expire  = state_r == ST_WAIT && tick && tickCnt_r + 16'h1 == waitLat_r;
    // more than four waits, i.e. first tick past the product
    assign success = state_r == ST_WATCH && !tripValid && tick
        && tickCnt_r == 16'(SUCCESS_MULT) * waitLat_r;
    assign succClr = wrEn && wrAddr[4:0] == REG_SUCC && mapped(wrAddr) && wrVal == 16'h0;

    // settings; out-of-range select, limit and wait values are refused and the old value kept
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            sel_r   <= 16'h0;
            lim_r   <= 16'h0;
            wait_r  <= WAIT_RST;
            coast_r <= COAST_OFF;
            term_r  <= 16'h0;
        end else if (wrEn && mapped(wrAddr)) begin
            case (wrAddr[4:0])
                REG_SEL:   if (wrVal <= SEL_MAX) sel_r <= wrVal;
                REG_LIM:   if (wrVal <= LIM_DIR_MAX || holdMode(wrVal)) lim_r <= wrVal;
                REG_WAIT:  if (wrVal <= WAIT_MAX) wait_r <= wrVal;
                REG_COAST: coast_r <= wrVal;
                REG_TERM:  term_r <= wrVal;
                default:   ;
            endcase
        end
    end

    // success counter; a success in the clearing cycle still counts
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN)
            succ_r <= 16'h0;
        else if (success)
            succ_r <= succClr ? 16'h1 : (succ_r == 16'hffff ? succ_r : succ_r + 16'h1);
        else if (succClr)
            succ_r <= 16'h0;
    end

    // register read mux
    always_comb begin
        rdData = 32'h0;
        case (rdAddr[4:0])
            REG_SEL:   rdData[15:0] = sel_r;
            REG_LIM:   rdData[15:0] = lim_r;
            REG_WAIT:  rdData[15:0] = wait_r;
            REG_SUCC:  rdData[15:0] = succ_r;
            REG_COAST: rdData[15:0] = coast_r;
            REG_TERM:  rdData[15:0] = term_r;
            REG_STAT: begin
                rdData[STAT_FAIL_LSB +: 4]  = failCnt_r;
                rdData[STAT_CODE_LSB +: 5]  = code_r;
                rdData[STAT_STATE_LSB +: 3] = state_r;
            end
            default:   rdData = 32'h0;
        endcase
        if (!mapped(rdAddr))
            rdData = 32'h0;
    end

    // retry sequencer
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_r   <= ST_RUN;
            code_r    <= OVERCURRENT_TRIP_A;
            failCnt_r <= 4'h0;
            waitLat_r <= WAIT_RST;
            tickClr_r <= 1'b0;
        end else begin
            tickClr_r <= 1'b0;
            unique case (state_r)
                ST_RUN: begin
                    if (tripValid) begin
                        code_r    <= tripCode;
                        failCnt_r <= 4'h0;
                        // zero wait behaves as one unit
                        waitLat_r <= wait_r == 16'h0 ? WAIT_ZERO : wait_r;
                        tickClr_r <= 1'b1;
                        state_r   <= retryOk ? ST_WAIT : ST_HOLD;
                    end
                end
                ST_WAIT: begin
                    // later trips while waiting leave the record alone
                    if (expire) begin
                        failCnt_r <= failCnt_r + 4'h1;
                        tickClr_r <= 1'b1;
                        state_r   <= ST_WATCH;
                    end
                end
                ST_WATCH: begin
                    if (tripValid) begin
                        tickClr_r <= 1'b1;
                        if (!retryOk)
                            state_r <= ST_HOLD;
                        else if (failCnt_r >= allowed(lim_r))
                            state_r <= ST_EXCESS;
                        else
                            state_r <= ST_WAIT;
                    end else if (success) begin
                        failCnt_r <= 4'h0;
                        state_r   <= ST_RUN;
                    end
                end
                ST_HOLD, ST_EXCESS: begin
                    // only an outside reset leaves a held trip
                    if (extSync_r[1])
                        state_r <= ST_RUN;
                end
                default: state_r <= ST_HOLD;
            endcase
        end
    end

    // ticks elapsed in the current wait or watch interval
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN)
            tickCnt_r <= 16'h0;
        else if (tickClr_r)
            tickCnt_r <= 16'h0;
        else if (tick && tickCnt_r != 16'hffff)
            tickCnt_r <= tickCnt_r + 16'h1;
    end

    // restart strobes; retry clear leaves thermal and brake duty data
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            faultClearPulse <= 1'b0;
            restartPulse    <= 1'b0;
            restartFlying   <= 1'b0;
        end else begin
            faultClearPulse <= expire;
            restartPulse    <= expire;
            if (expire)
                restartFlying <= coast_r != COAST_OFF;
        end
    end

    // thermal data wipe only after power-on reset
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            porDone_r      <= 1'b0;
            thermDataClear <= 1'b0;
        end else begin
            porDone_r      <= 1'b1;
            thermDataClear <= !porDone_r;
        end
    end

    // status outputs follow state one cycle later
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            faultOut         <= 1'b0;
            retryActiveOut   <= 1'b0;
            terminalOut      <= 1'b0;
            retryExcessFault <= 1'b0;
            firstFaultCode   <= OVERCURRENT_TRIP_A;
        end else begin
            faultOut         <= state_r == ST_HOLD || state_r == ST_EXCESS
                || (state_r == ST_WAIT && holdMode(lim_r));
            retryActiveOut   <= state_r == ST_WAIT;
            terminalOut      <= (term_r == TERM_POS && state_r == ST_WAIT)
                || (term_r == TERM_NEG && state_r != ST_WAIT);
            retryExcessFault <= state_r == ST_EXCESS;
            firstFaultCode   <= code_r;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    unsel_trip_a: assert property (state_r == ST_RUN && tripValid && !inSet(sel_r, tripCode)
        |=> state_r == ST_HOLD ##1 faultOut) else $error("unselected fault started a retry");
    limit_zero_a: assert property (state_r == ST_RUN && tripValid && lim_r == 16'h0
        |=> state_r == ST_HOLD) else $error("retry with limit zero");
    wait_zero_a: assert property (state_r == ST_RUN && tripValid && wait_r == 16'h0
        |=> waitLat_r == WAIT_ZERO) else $error("zero wait not one unit");
    excess_trip_a: assert property (state_r == ST_WATCH && tripValid && retryOk
        && failCnt_r >= allowed(lim_r) |=> state_r == ST_EXCESS ##1 retryExcessFault)
        else $error("excess fault missed");
    excess_hold_a: assert property (state_r == ST_EXCESS && !extSync_r[1]
        |=> state_r == ST_EXCESS) else $error("left excess without reset");
    restart_seq_a: assert property (expire |=> restartPulse && faultClearPulse
        && state_r == ST_WATCH && $past(state_r) == ST_WAIT) else $error("restart not issued");
    success_a: assert property (success && !succClr && succ_r != 16'hffff
        |=> failCnt_r == 4'h0 && succ_r == $past(succ_r) + 16'h1 && state_r == ST_RUN)
        else $error("success not counted");
    succ_clear_a: assert property (succClr && !success |=> succ_r == 16'h0)
        else $error("success count not cleared");
    first_code_a: assert property (state_r == ST_WAIT ##1 state_r == ST_WAIT
        |-> code_r == $past(code_r)) else $error("fault record overwritten");
    store_fault_a: assert property (state_r == ST_RUN && tripValid
        && tripCode == PARAM_STORE_FAULT && storeFaultAtPowerOn |=> state_r != ST_WAIT)
        else $error("retry on power-on store fault");
    hold_fault_a: assert property (state_r == ST_WAIT && holdMode(lim_r) && !wrEn
        |=> faultOut && retryActiveOut) else $error("fault output dropped in hold mode");
endmodule : frc_fault_retry

`default_nettype wire

// >>> sim/frc_drive_model.sv
// fault retry bench: model of the trip detectors and the motor output stage
// assumes the bench launches trips through fire and reads the two counters
`default_nettype none

module frc_drive_model (
    input  wire logic              ref_clk,
    input  wire logic              faultClearPulse,
    input  wire logic              restartPulse,
    output var logic               tripValid,
    output var frc_pkg::frc_code_t tripCode
);
    timeunit 1ns;
    timeprecision 1ps;
    import frc_pkg::*;
    int restarts = 0;  // restarts seen at the output stage
    int clears   = 0;  // fault clears seen at the detectors
    // idle detectors report nothing
    initial begin
        tripValid = 1'b0;
        tripCode  = OVERCURRENT_TRIP_A;
    end
    // one-cycle trip report, launched just after an edge
    task automatic fire(input frc_code_t c);
        @(posedge ref_clk);
        tripValid <= 1'b1;
        tripCode  <= c;
        @(posedge ref_clk);
        tripValid <= 1'b0;
    endtask : fire
    // count pulses so the bench can tie restarts to clears
    always @(posedge ref_clk) begin
        if (restartPulse === 1'b1) restarts <= restarts + 1;
        if (faultClearPulse === 1'b1) clears <= clears + 1;
    end
endmodule : frc_drive_model

`default_nettype wire

// >>> sim/tb_top.sv
// fault retry bench: selector table, register checks, excess trip
// assumes the sequencer at TICK_CYCLES 8 and the trip model beside it
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import frc_pkg::*;
    typedef struct packed {logic [15:0] sel; logic [15:0] lim; frc_code_t code; logic ret;} frc_row_t;
    localparam frc_row_t ROWS [11] = '{
        '{16'h0000, 16'h0001, MOTOR_THERMAL_TRIP, 1'b1}, '{16'h0001, 16'h0001, OVERCURRENT_TRIP_B, 1'b1},
        '{16'h0001, 16'h0001, OVERVOLTAGE_TRIP_A, 1'b0}, '{16'h0002, 16'h0065, OVERVOLTAGE_TRIP_C, 1'b1},
        '{16'h0002, 16'h0001, OVERCURRENT_TRIP_A, 1'b0}, '{16'h0003, 16'h0001, OVERVOLTAGE_TRIP_B, 1'b1},
        '{16'h0004, 16'h0001, MOTOR_THERMAL_TRIP, 1'b0}, '{16'h0004, 16'h006e, GROUND_FAULT_TRIP, 1'b1},
        '{16'h0005, 16'h0001, OVERCURRENT_TRIP_B, 1'b0}, '{16'h0005, 16'h0001, OVERCURRENT_TRIP_C, 1'b1},
        '{16'h0000, 16'h0000, OVERCURRENT_TRIP_A, 1'b0}};
    logic ref_clk = 1'b0, resetn = 1'b0, extResetReq = 1'b0, storeFault = 1'b0;
    logic tripValid, faultOut, retryActiveOut, terminalOut, retryExcessFault;
    logic faultClearPulse, restartPulse, restartFlying, thermDataClear;
    frc_code_t tripCode, firstFaultCode;
    frc_axi_req_t req = '0;  // bus master request, driven by the tasks only
    frc_axi_rsp_t rsp;
    int miscompares = 0, checksDone = 0, thermCnt = 0, nSucc = 0, n0 = 0;
    frc_row_t r;
    frc_fault_retry #(.TICK_CYCLES(8)) frc_fault_retry_inst (.ref_clk(ref_clk), .resetn(resetn),
        .axiReq(req), .axiRsp(rsp), .tripValid(tripValid), .tripCode(tripCode), .storeFaultAtPowerOn(storeFault),
        .extResetReq(extResetReq), .faultOut(faultOut), .retryActiveOut(retryActiveOut),
        .terminalOut(terminalOut), .retryExcessFault(retryExcessFault), .faultClearPulse(faultClearPulse),
        .restartPulse(restartPulse), .restartFlying(restartFlying), .thermDataClear(thermDataClear),
        .firstFaultCode(firstFaultCode));
    frc_drive_model frc_drive_model_inst (.ref_clk(ref_clk), .faultClearPulse(faultClearPulse),
        .restartPulse(restartPulse), .tripValid(tripValid), .tripCode(tripCode));
    // 200 MHz clock
    initial forever #2.5 ref_clk = ~ref_clk;
    // power-on clear pulses, counted to catch one on a retry
    always @(posedge ref_clk) if (thermDataClear === 1'b1) thermCnt <= thermCnt + 1;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // write: address and data offered together, held until taken
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req.awaddr <= {27'h0, a};
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do @(posedge ref_clk); while (!(rsp.awready === 1'b1 && rsp.wready === 1'b1));
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(posedge ref_clk); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk("bresp", rsp.bresp, RESP_OKAY);
    endtask : axw
    // read and compare data and response at the answering edge
    task automatic axr(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        req.araddr <= {27'h0, a};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge ref_clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge ref_clk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk("rdata", rsp.rdata, e);
        chk("rresp", rsp.rresp, er);
    endtask : axr
    // external reset long enough for the pin synchroniser
    task automatic extReset();
        extResetReq <= 1'b1;
        repeat (4) @(posedge ref_clk);
        extResetReq <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : extReset
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrapUp
    // watchdog, well past the expected 1400 or so cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        wrapUp();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        axr(REG_SEL, 32'h0, RESP_OKAY);
        axr(REG_LIM, 32'h0, RESP_OKAY);
        axr(REG_WAIT, 32'h0000000a, RESP_OKAY);
        axr(REG_SUCC, 32'h0, RESP_OKAY);
        axr(REG_COAST, 32'h0000270f, RESP_OKAY);
        axr(5'h1c, 32'h0, RESP_SLVERR);
        axw(REG_WAIT, 32'h00000e11);
        axr(REG_WAIT, 32'h0000000a, RESP_OKAY);
        axw(REG_WAIT, 32'h00000e10);
        axr(REG_WAIT, 32'h00000e10, RESP_OKAY);
        axw(REG_WAIT, 32'h0);
        axw(REG_TERM, 32'h00000040);
        $display("test registers done");
        // zero wait gives one 0.1 s tick, success after five
        for (int i = 0; i < 11; i++) begin
            r = ROWS[i];
            n0 = frc_drive_model_inst.restarts;
            nSucc += int'(r.ret);
            axw(REG_SEL, {16'h0, r.sel});
            axw(REG_LIM, {16'h0, r.lim});
            frc_drive_model_inst.fire(r.code);
            repeat (3) @(posedge ref_clk);
            chk("active", retryActiveOut, r.ret);
            chk("fault", faultOut, !r.ret || r.lim > 16'h0064);
            chk("terminal", terminalOut, r.ret);
            frc_drive_model_inst.fire(DRIVE_THERMAL_TRIP);
            repeat (2) @(posedge ref_clk);
            chk("first", firstFaultCode, r.code);
            repeat (80) @(posedge ref_clk);
            chk("restarts", 32'(frc_drive_model_inst.restarts - n0), r.ret);
            chk("flying", restartFlying, 1'b0);
            extReset();
        end
        $display("test selector table done");
        axr(REG_SUCC, 32'(nSucc), RESP_OKAY);
        axw(REG_SUCC, 32'h5);
        axr(REG_SUCC, 32'(nSucc), RESP_OKAY);
        axw(REG_SUCC, 32'h0);
        axr(REG_SUCC, 32'h0, RESP_OKAY);
        $display("test success count done");
        // trips inside the watch window until the limit runs out
        axw(REG_SEL, 32'h0);
        axw(REG_LIM, 32'h2);
        axw(REG_COAST, 32'h5);
        axw(REG_TERM, 32'h000000a4);
        n0 = frc_drive_model_inst.restarts;
        for (int k = 0; k < 4; k++) begin
            frc_drive_model_inst.fire(OVERCURRENT_TRIP_A);
            repeat (20) @(posedge ref_clk);
        end
        chk("restarts", 32'(frc_drive_model_inst.restarts - n0), 32'h2);
        chk("excess", retryExcessFault, 1'b1);
        chk("flying", restartFlying, 1'b1);
        chk("terminal", terminalOut, 1'b1);
        chk("clears", 32'(frc_drive_model_inst.clears), 32'(frc_drive_model_inst.restarts));
        chk("thermal", 32'(thermCnt), 32'h1);
        extReset();
        chk("excess", retryExcessFault, 1'b0);
        // store fault flagged at power-on must hold the trip
        storeFault <= 1'b1;
        frc_drive_model_inst.fire(PARAM_STORE_FAULT);
        repeat (3) @(posedge ref_clk);
        chk("active", retryActiveOut, 1'b0);
        $display("test excess done");
        wrapUp();
    end
endmodule : tb_top

`default_nettype wire
